// >>> rtl/epc_pkg.sv
// constants for the enable-pin low-power control block
package epc_pkg;
  // clock rate and enable-pin filter time
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned FILTER_US = 140;
  localparam longint unsigned FILTER_CYCLES_L = (longint'(FILTER_US) * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned FILTER_CYCLES = int'(FILTER_CYCLES_L);
  localparam int FILTER_W = 16;
  // pin group widths
  localparam int SEG_W = 9;
  localparam int OUTC_W = 4;
  localparam int OUTA_W = 2;
  localparam int INB_W = 3;
  localparam int BIDIR_W = 2;
  // restart address after a reset
  localparam logic [10:0] RESTART_ADDR = 11'h000;
  // reset values
  localparam logic [BIDIR_W-1:0] BIDIR_OE_RST = 2'h0;
  localparam logic [SEG_W-1:0] SEG_RST = 9'h000;
  localparam logic [OUTC_W-1:0] OUTC_RST = 4'h0;
  localparam logic [OUTA_W-1:0] OUTA_RST = 2'h0;
  typedef enum logic [1:0] {EPC_RUN, EPC_HALT, EPC_STOP} epc_mode_e;
endpackage

// >>> rtl/epc_enable_pin_ctrl.sv
// enable-pin gating of synthesizer, clock-stop, reset, and low-power pin states
`timescale 1ns/1ps
// Summary of operation
// R1: halt holds all port output states
// R2: clock-stop makes bidir port bits inputs
// R3: clock-stop keeps output-only ports driving
// R4: input-only pins always internally pulled down
// R5: clock-stop drives all segments low
// R6: halt keeps the segment pattern shown
// R7: synthesizer runs only with enable high
// R8: enable low disables synthesizer automatically
// R9: disabled synthesizer pins float
// R10: software may disable synthesizer anytime
// R11: clock-stop acts only with enable low
// R12: enable high makes clock-stop a no-operation
// R13: enable rising edge requests a reset
// R14: clock-stop pulls crystal in low, out high
// R15: ignore enable pulses under 140 us
// R16: apply enable reset at next carry flag
// R17: restart at address zero after stop release
// R18: halt keeps peripherals running and settings
// R19: synchronise enable before deciding clock-stop
module epc_enable_pin_ctrl #(
  parameter int unsigned FILTER_CYCLES = epc_pkg::FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable_pin,
  input wire logic halt_req,
  input wire logic halt_release,
  input wire logic stop_instr,
  input wire logic basic_timer_carry_flag,
  input wire logic synth_sw_enable,
  input wire logic [epc_pkg::BIDIR_W-1:0] bidir_out_val,
  input wire logic [epc_pkg::BIDIR_W-1:0] bidir_out_en,
  input wire logic [epc_pkg::OUTA_W-1:0] output_only_port_a_val,
  input wire logic [epc_pkg::OUTC_W-1:0] output_only_port_c_val,
  input wire logic tone_val,
  input wire logic [epc_pkg::SEG_W-1:0] segment_val,
  output logic enable_level,
  output logic cpu_run,
  output logic stop_nop,
  output logic enable_reset,
  output logic [10:0] restart_addr,
  output logic osc_stop,
  output logic synth_enable,
  output logic vco_high_band_input_en,
  output logic vco_low_band_input_en,
  output logic phase_error_output_oe,
  output logic [epc_pkg::BIDIR_W-1:0] bidir_port_o,
  output logic [epc_pkg::BIDIR_W-1:0] bidir_port_oe,
  output logic [epc_pkg::OUTA_W-1:0] output_only_port_a,
  output logic [epc_pkg::OUTC_W-1:0] output_only_port_c,
  output logic tone_output_pin,
  output logic [epc_pkg::SEG_W-1:0] segment_output,
  output logic [epc_pkg::INB_W-1:0] input_only_port_pulldown,
  output logic crystal_input_pulldown,
  output logic crystal_output,
  output logic crystal_output_oe
);
  // stop-state decode, shared by the mode, pin and synthesizer groups
  function automatic logic is_stop(input epc_pkg::epc_mode_e m);
    return (m == epc_pkg::EPC_STOP);
  endfunction

  // run-state decode, shared by the pin sampling and the status output
  function automatic logic is_run(input epc_pkg::epc_mode_e m);
    return (m == epc_pkg::EPC_RUN);
  endfunction

  // last filter count, sized to the counter on purpose
  localparam logic [epc_pkg::FILTER_W-1:0] FILT_LAST = epc_pkg::FILTER_W'(FILTER_CYCLES - 1);

  // synchroniser state
  logic sync_a;
  logic sync_b;
  logic next_sync_a;
  logic next_sync_b;
  // enable pin filter state
  logic filt;
  logic [epc_pkg::FILTER_W-1:0] cnt;
  logic next_filt;
  logic [epc_pkg::FILTER_W-1:0] next_cnt;
  logic rise;
  // mode and reset request state
  epc_pkg::epc_mode_e mode;
  epc_pkg::epc_mode_e next_mode;
  logic rst_pend;
  logic next_rst_pend;
  logic rst_pulse;
  logic next_rst_pulse;
  logic stop_nop_r;
  logic next_stop_nop;
  // held pin state
  logic [epc_pkg::BIDIR_W-1:0] bid_o;
  logic [epc_pkg::BIDIR_W-1:0] bid_oe;
  logic [epc_pkg::OUTA_W-1:0] oa;
  logic [epc_pkg::OUTC_W-1:0] oc;
  logic tone;
  logic [epc_pkg::SEG_W-1:0] seg;
  logic [epc_pkg::BIDIR_W-1:0] next_bid_o;
  logic [epc_pkg::BIDIR_W-1:0] next_bid_oe;
  logic [epc_pkg::OUTA_W-1:0] next_oa;
  logic [epc_pkg::OUTC_W-1:0] next_oc;
  logic next_tone;
  logic [epc_pkg::SEG_W-1:0] next_seg;
  // synthesizer gate state
  logic synth;
  logic next_synth;

  // two flops; only sync_b is read outside this group, as sync_a may be metastable
  always_comb begin
    next_sync_a = enable_pin; // [R19]
    next_sync_b = sync_a; // [R19]
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  // filter: the level is accepted only after it stays stable for the full count
  always_comb begin
    next_filt = filt;
    next_cnt = '0;
    if (sync_b != filt) begin
      if (cnt >= FILT_LAST) begin
        next_filt = sync_b; // [R15]
      end else begin
        next_cnt = cnt + 1'b1; // [R15]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      filt <= 1'b0;
      cnt <= '0;
    end else begin
      filt <= next_filt;
      cnt <= next_cnt;
    end
  end

  // a short pulse restarts the count, so neither control nor level flag sees it
  assign rise = next_filt && !filt; // [R13]

  always_comb begin
    next_mode = mode;
    next_rst_pend = rst_pend;
    next_rst_pulse = 1'b0;
    next_stop_nop = 1'b0;
    case (mode)
      epc_pkg::EPC_RUN: begin
        if (stop_instr && !filt) begin
          next_mode = epc_pkg::EPC_STOP; // [R11]
        end else if (stop_instr) begin
          next_stop_nop = 1'b1; // [R12]
        end else if (halt_req) begin
          next_mode = epc_pkg::EPC_HALT;
        end
      end
      epc_pkg::EPC_HALT: begin
        if (halt_release) begin
          next_mode = epc_pkg::EPC_RUN;
        end
      end
      epc_pkg::EPC_STOP: begin
        // only a filtered rising edge leaves clock-stop; it waits in halt for the carry
        if (rise) begin
          next_mode = epc_pkg::EPC_HALT; // [R13]
        end
      end
      default: begin
        next_mode = epc_pkg::EPC_RUN;
      end
    endcase
    // reset waits for the carry flag so it lines up with the timer tick
    if (rst_pend && basic_timer_carry_flag && !is_stop(mode)) begin
      next_rst_pend = 1'b0; // [R16]
      next_rst_pulse = 1'b1; // [R16]
      next_mode = epc_pkg::EPC_RUN; // [R17]
    end
    // an edge in the same cycle as an apply is kept: the set wins
    if (rise) begin
      next_rst_pend = 1'b1; // [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode <= epc_pkg::EPC_RUN;
      rst_pend <= 1'b0;
      rst_pulse <= 1'b0;
      stop_nop_r <= 1'b0;
    end else begin
      mode <= next_mode;
      rst_pend <= next_rst_pend;
      rst_pulse <= next_rst_pulse;
      stop_nop_r <= next_stop_nop;
    end
  end

  // pins follow the cpu only in run; halt leaves them alone [R1] [R6] [R18]
  always_comb begin
    next_bid_o = bid_o;
    next_bid_oe = bid_oe;
    next_oa = oa;
    next_oc = oc;
    next_tone = tone;
    next_seg = seg;
    if (is_run(mode)) begin
      next_bid_o = bidir_out_val;
      next_bid_oe = bidir_out_en;
      next_oa = output_only_port_a_val;
      next_oc = output_only_port_c_val; // [R3]
      next_tone = tone_val;
      next_seg = segment_val;
    end
    // blanking is decided from the next mode so the first stop cycle is already dark
    if (is_stop(next_mode)) begin
      next_seg = epc_pkg::SEG_RST; // [R5]
      next_bid_oe = epc_pkg::BIDIR_OE_RST; // [R2]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bid_o <= '0;
      bid_oe <= epc_pkg::BIDIR_OE_RST;
      oa <= epc_pkg::OUTA_RST;
      oc <= epc_pkg::OUTC_RST;
      tone <= 1'b0;
      seg <= epc_pkg::SEG_RST;
    end else begin
      bid_o <= next_bid_o;
      bid_oe <= next_bid_oe;
      oa <= next_oa;
      oc <= next_oc;
      tone <= next_tone;
      seg <= next_seg;
    end
  end

  // software can only narrow the gate; it can never run the loop with enable low
  always_comb begin
    next_synth = filt && synth_sw_enable; // [R7] [R8] [R10]
    if (is_stop(next_mode)) begin
      next_synth = 1'b0; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      synth <= 1'b0;
    end else begin
      synth <= next_synth;
    end
  end

  // one pull-down enable per input-only pin; they never switch off
  for (genvar i = 0; i < epc_pkg::INB_W; i++) begin : g_pulldown
    assign input_only_port_pulldown[i] = 1'b1; // [R4]
  end

  assign enable_level = filt; // [R15]
  assign cpu_run = is_run(mode);
  assign stop_nop = stop_nop_r;
  assign enable_reset = rst_pulse;
  assign restart_addr = epc_pkg::RESTART_ADDR; // [R17]
  assign osc_stop = is_stop(mode);
  assign synth_enable = synth;
  assign vco_high_band_input_en = synth; // [R9]
  assign vco_low_band_input_en = synth; // [R9]
  assign phase_error_output_oe = synth; // [R9]
  assign bidir_port_o = bid_o;
  assign bidir_port_oe = bid_oe; // [R1] [R2]
  assign output_only_port_a = oa; // [R3]
  assign output_only_port_c = oc; // [R3]
  assign tone_output_pin = tone; // [R3]
  assign segment_output = seg; // [R5] [R6]
  // the crystal pins are only forced while the oscillator is stopped
  assign crystal_input_pulldown = is_stop(mode); // [R14]
  assign crystal_output = 1'b1; // [R14]
  assign crystal_output_oe = is_stop(mode); // [R14]
endmodule // epc_enable_pin_ctrl

// >>> testbench/epc_checker.sv
// checker of the enable-pin control block ports
`timescale 1ns/1ps
module epc_checker #(parameter int unsigned FILTER_CYCLES = 4) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable_pin,
  input wire logic stop_instr,
  input wire logic basic_timer_carry_flag,
  input wire logic synth_sw_enable,
  input wire logic enable_level,
  input wire logic cpu_run,
  input wire logic stop_nop,
  input wire logic enable_reset,
  input wire logic [10:0] restart_addr,
  input wire logic osc_stop,
  input wire logic synth_enable,
  input wire logic vco_high_band_input_en,
  input wire logic phase_error_output_oe,
  input wire logic [1:0] bidir_port_oe,
  input wire logic [3:0] output_only_port_c,
  input wire logic [8:0] segment_output,
  input wire logic crystal_input_pulldown,
  input wire logic crystal_output,
  input wire logic crystal_output_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // raw cycles the pin has differed from the filtered level
  logic [15:0] diff_cnt;
  logic [15:0] next_diff_cnt;
  always_comb next_diff_cnt = (enable_pin == enable_level) ? 16'h0000 : diff_cnt + 16'h0001;
  always_ff @(posedge clk) diff_cnt <= nrst ? next_diff_cnt : 16'h0000;
  sequence s_stop_cmd; stop_instr && cpu_run && !enable_level; endsequence
  sequence s_nop_cmd; stop_instr && cpu_run && enable_level; endsequence
  a_synth_gate: assert property (synth_enable |-> $past(enable_level && synth_sw_enable))
    else $error("synthesizer on without both enables");
  a_synth_float: assert property (vco_high_band_input_en == synth_enable && phase_error_output_oe == synth_enable)
    else $error("synthesizer pins not floating when disabled");
  a_stop_nop: assert property (s_nop_cmd |=> stop_nop && cpu_run && !osc_stop)
    else $error("stop with enable high not a no-operation");
  a_stop_enter: assert property (s_stop_cmd |=> osc_stop && !stop_nop)
    else $error("stop with enable low not taken");
  a_stop_pins: assert property (osc_stop |-> segment_output == 9'h000 && bidir_port_oe == 2'h0
    && crystal_input_pulldown && crystal_output && crystal_output_oe && !synth_enable)
    else $error("pin states wrong in clock-stop");
  a_halt_hold: assert property (!cpu_run && !osc_stop && $past(!cpu_run && !osc_stop)
    |-> $stable(segment_output) && $stable(output_only_port_c))
    else $error("outputs changed while halted");
  a_reset_apply: assert property (enable_reset |-> $past(basic_timer_carry_flag) && cpu_run
    && restart_addr == 11'h000)
    else $error("enable reset not tied to timer carry");
  a_enable_filter: assert property (enable_level != $past(enable_level)
    |-> $past(diff_cnt) >= FILTER_CYCLES)
    else $error("short enable pulse passed the filter");
endmodule // epc_checker
bind epc_enable_pin_ctrl epc_checker #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (.*);

// >>> testbench/epc_switch.sv
// board enable switch model driving the enable pin
`timescale 1ns/1ps
module epc_switch (
  input wire logic clk,
  output logic enable_pin
);
  initial enable_pin = 1'b0;
  // the switch moves only after a falling edge, clear of sampling
  task automatic drive(input logic level, input int hold);
    @(negedge clk) enable_pin = level;
    repeat (hold) @(negedge clk);
  endtask
endmodule // epc_switch

// >>> testbench/test_enable_pin_low_power_control.sv
// self-checking testbench of the enable-pin control block
`timescale 1ns/1ps
module test_enable_pin_low_power_control;
  localparam int FC = 4;
  logic clk = 1'b0, nrst = 1'b0, halt_req = 1'b0, halt_release = 1'b0, stop_instr = 1'b0;
  logic basic_timer_carry_flag = 1'b0, synth_sw_enable = 1'b0, tone_val = 1'b0;
  logic [1:0] bidir_out_val = 2'h3, bidir_out_en = 2'h3, output_only_port_a_val = 2'h0;
  logic [3:0] output_only_port_c_val = 4'h0;
  logic [8:0] segment_val = 9'h000;
  logic enable_pin, enable_level, cpu_run, stop_nop, enable_reset, osc_stop, synth_enable;
  logic vco_high_band_input_en, vco_low_band_input_en, phase_error_output_oe, tone_output_pin;
  logic crystal_input_pulldown, crystal_output, crystal_output_oe;
  logic [10:0] restart_addr;
  logic [1:0] bidir_port_o, bidir_port_oe, output_only_port_a;
  logic [3:0] output_only_port_c;
  logic [8:0] segment_output;
  logic [2:0] input_only_port_pulldown;
  int miscompares = 0;
  int n_tests = 0;
  always #2.5 clk = ~clk;
  epc_switch sw (.clk(clk), .enable_pin(enable_pin));
  epc_enable_pin_ctrl #(.FILTER_CYCLES(FC)) dut (.*);
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask
  task automatic t_synth_nop();
    synth_sw_enable = 1'b1;
    sw.drive(1'b1, FC + 6);
    chk("synth", 16'h1, synth_enable);
    chk("vco_in_en", 16'h1, vco_high_band_input_en);
    pulse(stop_instr);
    chk("nop", 16'h3, {stop_nop, cpu_run});
    @(negedge clk) synth_sw_enable = 1'b0;
    @(negedge clk);
    chk("synth_sw_off", 16'h0, synth_enable);
    synth_sw_enable = 1'b1;
    sw.drive(1'b0, 2);
    sw.drive(1'b1, FC + 6);
    chk("glitch_level", 16'h1, enable_level);
    sw.drive(1'b0, FC + 6);
    chk("synth_auto_off", 16'h0, {synth_enable, phase_error_output_oe});
  endtask
  task automatic t_halt();
    segment_val = 9'h1a5;
    output_only_port_c_val = 4'h9;
    pulse(halt_req);
    segment_val = 9'h000;
    output_only_port_c_val = 4'h0;
    repeat (3) @(negedge clk);
    chk("halt_seg", 16'h1a5, segment_output);
    chk("halt_outc", 16'h9, output_only_port_c);
    pulse(halt_release);
    chk("run", 16'h1, cpu_run);
  endtask
  task automatic t_stop_reset();
    output_only_port_c_val = 4'h6;
    segment_val = 9'h0ff;
    @(negedge clk);
    pulse(stop_instr);
    chk("stop", 16'h1, osc_stop);
    chk("stop_seg", 16'h0, segment_output);
    chk("stop_bidir_oe", 16'h0, bidir_port_oe);
    chk("stop_outc", 16'h6, output_only_port_c);
    chk("xtal", 16'h7, {crystal_input_pulldown, crystal_output, crystal_output_oe});
    chk("pulldown", 16'h7, input_only_port_pulldown);
    sw.drive(1'b1, FC + 6);
    chk("woken_halt", 16'h0, {osc_stop, cpu_run});
    pulse(basic_timer_carry_flag);
    chk("en_reset", 16'h1, enable_reset);
    chk("restart", 16'h800, {cpu_run, restart_addr});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_synth_nop();
    t_halt();
    t_stop_reset();
    end_of_test();
  end
  // the tests need under a hundred cycles (about 75); the 4000-cycle limit leaves ample room
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule // test_enable_pin_low_power_control
